// ### hw/frds_map.svh
// Register offsets, fields, reset values and timing counts of the block store.
// Notes on behaviour
// - Sync to the data stream, correct blocks where possible, identify block type.
// - Host sets acquisition and loss counts; sync logic applies them.
// - Local buffer holds at most 85 received blocks.
// - Each entry carries status byte: 3-bit type, 3-bit error, buffer bit, spare.
// - Raise host interrupt when stored block count reaches host fill threshold.
// - Keep every received block, processed or not, for host download.
// - With switching enabled, retune alone to better equivalent frequency.
// - Check list, quality, image, identity; return if none fits; 15 ms budget.
// - Host can disable switching and set the signal strength start threshold.
// - Accept only candidates meeting configurable minimum strength, avoiding toggling.
// - Pause when left plus right magnitude stays below programmable deviation level.
// - Silence counts as pause only after programmable minimum duration.
// - With pause detection on, jump frequency only during a detected pause; code waits for it before the first candidate only.
// - With pause detection off, switch at once when strength drops.
// - Decoded identity code and frequency list drive the switching process.
// - Network and traffic info switch temporarily to a channel with bulletin.
// - Traffic flags qualify stations found during automatic scan.
// - Mute audio for the whole of every frequency update.
// - Images found during autonomous operation raise no image interrupt.
`ifndef FRDS_MAP_SVH
`define FRDS_MAP_SVH
`define FRDS_REG_CTRL 8'h00
`define FRDS_REG_SYNC 8'h04
`define FRDS_REG_FILL 8'h08
`define FRDS_REG_AFTH 8'h0C
`define FRDS_REG_PAUS 8'h10
`define FRDS_REG_STAT 8'h14
`define FRDS_REG_DATA 8'h18
`define FRDS_REG_IDNT 8'h1C
`define FRDS_REG_FREQ 8'h20
`define FRDS_CTRL_AF_EN 0
`define FRDS_CTRL_PAUSE_EN 1
`define FRDS_CTRL_TA_EN 2
`define FRDS_CTRL_SCAN_TA 3
`define FRDS_CTRL_FILL_EN 4
`define FRDS_CTRL_RST 8'h13
`define FRDS_SYNC_RST 8'h43
`define FRDS_FILL_RST 7'h40
`define FRDS_AFTH_RST 16'h3020
`define FRDS_PAUS_RST 32'h0100_0200
`define FRDS_CLK_KHZ 125000
`define FRDS_SWITCH_MS 15
`define FRDS_PI_WAIT_MS 200
`define FRDS_SWITCH_CYC (`FRDS_SWITCH_MS * `FRDS_CLK_KHZ)
`define FRDS_PI_WAIT_CYC (`FRDS_PI_WAIT_MS * `FRDS_CLK_KHZ)
`endif

// ### hw/frds_pkg.sv
// Types shared by the block store and the block synchroniser.
package frds_pkg;
  typedef enum logic [2:0] {
    BLK_A = 3'h0, BLK_B = 3'h1, BLK_C = 3'h2, BLK_CP = 3'h3,
    BLK_D = 3'h4, BLK_NONE = 3'h7
  } frds_blk_t;
  typedef enum logic [1:0] {
    SY_SEARCH = 2'h0, SY_ACQ = 2'h1, SY_LOCK = 2'h2
  } frds_sync_t;
  typedef enum logic [2:0] {
    AF_IDLE = 3'h0, AF_WAIT = 3'h1, AF_TUNE = 3'h2, AF_MEAS = 3'h3,
    AF_PICHK = 3'h4, AF_RET = 3'h5, AF_RWAIT = 3'h6
  } frds_af_t;
endpackage

// ### hw/frds_block_sync.sv
// Block synchroniser: offset search, single-bit correction, type detection.
`timescale 1ns/1ps
module frds_block_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bit_in,
  input wire logic bit_valid,
  input wire logic [3:0] acq_good,
  input wire logic [3:0] loss_bad,
  output logic blk_valid,
  output logic [15:0] blk_data,
  output frds_pkg::frds_blk_t blk_type,
  output logic [2:0] blk_err,
  output logic synced
);
  import frds_pkg::*;

  function automatic logic [9:0] syn(input logic [25:0] w);
    logic [9:0] r;
    logic fb;
    r = 10'h000;
    for (int i = 25; i >= 0; i--) begin
      fb = r[9] ^ w[i];
      r = {r[8:0], 1'b0};
      if (fb) r = r ^ 10'h1B9;
    end
    return r;
  endfunction

  function automatic logic [9:0] osyn(input frds_blk_t t);
    case (t)
      BLK_A: osyn = syn({16'h0000, 10'h0FC});
      BLK_B: osyn = syn({16'h0000, 10'h198});
      BLK_C: osyn = syn({16'h0000, 10'h168});
      BLK_CP: osyn = syn({16'h0000, 10'h350});
      default: osyn = syn({16'h0000, 10'h1B4});
    endcase
  endfunction

  function automatic frds_blk_t nxt_t(input frds_blk_t t);
    case (t)
      BLK_A: nxt_t = BLK_B;
      BLK_B: nxt_t = BLK_C;
      BLK_C, BLK_CP: nxt_t = BLK_D;
      default: nxt_t = BLK_A;
    endcase
  endfunction

  logic [25:0] sh_r;
  logic [4:0] bc_r;
  logic [3:0] cnt_r;
  frds_sync_t st_r;
  frds_blk_t exp_r;
  logic [25:0] w;
  logic [9:0] s;
  frds_blk_t hit;
  logic [4:0] ep;
  logic [9:0] es;

  assign w = {sh_r[24:0], bit_in};
  assign s = syn(w);
  assign synced = (st_r == SY_LOCK);

  // Exact offset match; C and C' share a slot in the group.
  always_comb begin
    hit = BLK_NONE;
    es = osyn(exp_r);
    if (st_r == SY_SEARCH) begin
      for (int k = 4; k >= 0; k--)
        if (s == osyn(frds_blk_t'(3'(k)))) hit = frds_blk_t'(3'(k));
    end else if (s == es) hit = exp_r;
    else if (exp_r == BLK_C && s == osyn(BLK_CP)) hit = BLK_CP;
    if (hit != BLK_NONE) es = osyn(hit);
    ep = 5'h1F;
    for (int i = 0; i < 26; i++)
      if ((s ^ syn(26'(1) << i)) == es) ep = 5'(i);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sh_r <= 26'h0000000;
      bc_r <= 5'h00;
      cnt_r <= 4'h0;
      st_r <= SY_SEARCH;
      exp_r <= BLK_A;
      blk_valid <= 1'b0;
      blk_data <= 16'h0000;
      blk_type <= BLK_NONE;
      blk_err <= 3'h0;
    end else begin
      blk_valid <= 1'b0;
      if (bit_valid) begin
        sh_r <= w;
        bc_r <= (bc_r == 5'd25) ? 5'h00 : bc_r + 5'h01;
        if (st_r == SY_SEARCH) begin
          if (hit != BLK_NONE) begin
            st_r <= SY_ACQ;
            cnt_r <= 4'h1;
            bc_r <= 5'h00;
            exp_r <= nxt_t(hit);
            blk_valid <= 1'b1;
            blk_data <= w[25:10];
            blk_type <= hit;
            blk_err <= 3'h0;
          end
        end else if (bc_r == 5'd25) begin
          exp_r <= nxt_t(exp_r);
          blk_valid <= 1'b1;
          blk_type <= (hit != BLK_NONE) ? hit : exp_r;
          blk_data <= w[25:10];
          blk_err <= 3'h0;
          if (hit != BLK_NONE) begin
            if (st_r == SY_ACQ && cnt_r + 4'h1 >= acq_good)
              st_r <= SY_LOCK;
            cnt_r <= (st_r == SY_ACQ) ? cnt_r + 4'h1 : 4'h0;
          end else if (st_r == SY_ACQ) begin
            st_r <= SY_SEARCH;
            blk_valid <= 1'b0;
          end else if (ep != 5'h1F) begin
            blk_data <= w[25:10] ^ 16'(26'(1) << ep >> 10);
            blk_err <= 3'h1;
            cnt_r <= 4'h0;
          end else begin
            blk_err <= 3'h2;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r + 4'h1 >= loss_bad) st_r <= SY_SEARCH;
          end
        end
      end
    end
  end
endmodule // frds_block_sync

// ### hw/frds_top.sv
// Radio data block store with frequency switching and pause detection.
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "frds_map.svh"
module frds_top #(
  parameter int DEPTH = 85,
  parameter int AFN = 8,
  parameter int SW_CYC = `FRDS_SWITCH_CYC,
  parameter int PI_CYC = `FRDS_PI_WAIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rds_bit,
  input wire logic rds_bit_valid,
  input wire logic [7:0] rssi,
  input wire logic audio_valid,
  input wire logic signed [15:0] audio_left,
  input wire logic signed [15:0] audio_right,
  input wire logic scan_active,
  input wire logic tune_done,
  input wire logic [7:0] cand_rssi,
  input wire logic image_det,
  output logic tune_req,
  output logic [7:0] tune_freq,
  output logic audio_mute,
  output logic image_irq,
  output logic fill_irq,
  output logic scan_accept
);
  import frds_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(AFN);
  localparam int SWW = $clog2(SW_CYC + 1);
  localparam int PIW = $clog2(PI_CYC + 1);

  generate
    if (DEPTH < 2 || DEPTH > 127 || AFN < 2 || (AFN & (AFN - 1)) != 0)
      $error("frds_top: DEPTH must be 2..127, AFN a power of two");
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++)
      if (sel[b]) o[b*8 +: 8] = n[b*8 +: 8];
    return o;
  endfunction

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  function automatic logic af_ok(input logic [7:0] c);
    return c >= 8'h01 && c <= 8'hCC;
  endfunction

  // Registers.
  logic [7:0] ctrl_r;
  logic [7:0] sync_r;
  logic [6:0] fill_r;
  logic [15:0] afth_r;
  logic [31:0] paus_r;
  logic [7:0] home_r;
  logic [7:0] taf_r;
  logic ack_r;
  logic take;
  logic rd_pop;
  logic [31:0] cur_w;

  // Sync outputs.
  logic bv;
  logic [15:0] bd;
  frds_blk_t bt;
  logic [2:0] be;
  logic synced;

  // Buffer.
  logic [23:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [6:0] cnt_r;
  logic lost_r;
  logic push;
  logic pop;

  // Decoded information.
  logic [15:0] pi_r;
  logic pi_ok_r;
  logic [4:0] grp_r;
  logic [4:0] pty_r;
  logic tp_r;
  logic ta_r;
  logic ms_r;
  logic eon_ta_r;
  logic pi_seen;
  logic good;
  logic [7:0] afl [AFN];
  logic [LW-1:0] ai_r;
  logic [LW:0] an_r;

  // Pause detection and switching.
  logic signed [16:0] sum;
  logic [16:0] mag;
  logic [15:0] qc_r;
  logic pause;
  frds_af_t st_r;
  logic [LW:0] idx_r;
  logic [$clog2(SW_CYC+1)-1:0] swt_r;
  logic [$clog2(PI_CYC+1)-1:0] pit_r;
  logic on_ta_r;
  logic last;
  logic auto_op;

  frds_block_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .bit_in(rds_bit),
    .bit_valid(rds_bit_valid),
    .acq_good(sync_r[3:0]),
    .loss_bad(sync_r[7:4]),
    .blk_valid(bv),
    .blk_data(bd),
    .blk_type(bt),
    .blk_err(be),
    .synced(synced)
  );

  assign take = wb_cyc_i && wb_stb_i && !ack_r;
  assign rd_pop = take && !wb_we_i && wb_adr_i == `FRDS_REG_DATA;
  assign wb_ack_o = ack_r;

  always_comb begin
    case (wb_adr_i)
      `FRDS_REG_CTRL: cur_w = {24'h000000, ctrl_r};
      `FRDS_REG_SYNC: cur_w = {24'h000000, sync_r};
      `FRDS_REG_FILL: cur_w = {25'h0000000, fill_r};
      `FRDS_REG_AFTH: cur_w = {16'h0000, afth_r};
      `FRDS_REG_PAUS: cur_w = paus_r;
      `FRDS_REG_STAT: cur_w = {16'h0000, 1'b0, cnt_r, lost_r, ms_r,
                               ta_r, tp_r, pause, st_r != AF_IDLE,
                               fill_irq, synced};
      `FRDS_REG_DATA: cur_w = {8'h00, cnt_r != 7'h00 ? mem[rp_r] : 24'h0};
      `FRDS_REG_IDNT: cur_w = {6'h00, an_r == '0 ? 1'b0 : 1'b1, pi_ok_r,
                               3'h0, pty_r, pi_r};
      `FRDS_REG_FREQ: cur_w = {16'h0000, taf_r, home_r};
      default: cur_w = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_r <= take;
      if (take && !wb_we_i) wb_dat_o <= cur_w;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= `FRDS_CTRL_RST;
      sync_r <= `FRDS_SYNC_RST;
      fill_r <= `FRDS_FILL_RST;
      afth_r <= `FRDS_AFTH_RST;
      paus_r <= `FRDS_PAUS_RST;
      taf_r <= 8'h00;
    end else if (take && wb_we_i) begin
      case (wb_adr_i)
        `FRDS_REG_CTRL: ctrl_r <= 8'(merge(32'(ctrl_r), wb_dat_i, wb_sel_i));
        `FRDS_REG_SYNC: sync_r <= 8'(merge(32'(sync_r), wb_dat_i, wb_sel_i));
        `FRDS_REG_FILL: fill_r <= 7'(merge(32'(fill_r), wb_dat_i, wb_sel_i));
        `FRDS_REG_AFTH: afth_r <= 16'(merge(32'(afth_r), wb_dat_i, wb_sel_i));
        `FRDS_REG_PAUS: paus_r <= merge(paus_r, wb_dat_i, wb_sel_i);
        `FRDS_REG_FREQ: if (wb_sel_i[1]) taf_r <= wb_dat_i[15:8];
        default: ;
      endcase
    end
  end

  // Every block is stored, whether or not it is decoded here; a full
  // buffer drops the new block and flags the next stored one.
  assign push = bv && cnt_r != 7'(DEPTH);
  assign pop = rd_pop && cnt_r != 7'h00;

  always_ff @(posedge clk) begin
    if (push) mem[wp_r] <= {bt, be, lost_r, 1'b0, bd};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= 7'h00;
      lost_r <= 1'b0;
    end else begin
      if (push) wp_r <= inc(wp_r);
      if (pop) rp_r <= inc(rp_r);
      cnt_r <= cnt_r + 7'(push) - 7'(pop);
      if (bv && !push) lost_r <= 1'b1;
      else if (push) lost_r <= 1'b0;
    end
  end

  assign fill_irq = ctrl_r[`FRDS_CTRL_FILL_EN] && fill_r != 7'h00 &&
                    cnt_r >= fill_r;

  // Decoding of identity, genre, traffic and frequency list.
  assign good = bv && be != 3'h2;
  assign pi_seen = good && bt == BLK_A;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pi_r <= 16'h0000;
      pi_ok_r <= 1'b0;
      grp_r <= 5'h1F;
      pty_r <= 5'h00;
      tp_r <= 1'b0;
      ta_r <= 1'b0;
      ms_r <= 1'b0;
      eon_ta_r <= 1'b0;
    end else if (!synced) begin
      grp_r <= 5'h1F;
    end else if (good) begin
      if (bt == BLK_A && st_r == AF_IDLE) begin
        pi_r <= bd;
        pi_ok_r <= 1'b1;
      end
      if (bt == BLK_B) begin
        grp_r <= bd[15:11];
        tp_r <= bd[10];
        pty_r <= bd[9:5];
        if (bd[15:12] == 4'h0) begin
          ta_r <= bd[4];
          ms_r <= bd[3];
        end
        if (bd[15:11] == 5'h1D) eon_ta_r <= bd[4];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (good && bt == BLK_C && grp_r == 5'h00 && st_r == AF_IDLE) begin
      if (af_ok(bd[15:8])) afl[ai_r] <= bd[15:8];
      if (af_ok(bd[7:0])) afl[ai_r + LW'(af_ok(bd[15:8]))] <= bd[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ai_r <= '0;
      an_r <= '0;
    end else if (good && bt == BLK_C && grp_r == 5'h00 &&
                 st_r == AF_IDLE) begin
      ai_r <= ai_r + LW'(af_ok(bd[15:8])) + LW'(af_ok(bd[7:0]));
      if (an_r < (LW+1)'(AFN - 1))
        an_r <= an_r + (LW+1)'(af_ok(bd[15:8])) + (LW+1)'(af_ok(bd[7:0]));
      else if (af_ok(bd[15:8]) || af_ok(bd[7:0]))
        an_r <= (LW+1)'(AFN);
    end
  end

  assign scan_accept = !ctrl_r[`FRDS_CTRL_SCAN_TA] || (tp_r && ta_r);

  // Audio pause detector on the mid signal.
  assign sum = 17'(audio_left) + 17'(audio_right);
  assign mag = sum[16] ? 17'(-sum) : 17'(sum);
  assign pause = qc_r >= paus_r[31:16];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      qc_r <= 16'h0000;
    end else if (audio_valid) begin
      if (mag >= {1'b0, paus_r[15:0]}) qc_r <= 16'h0000;
      else if (qc_r != 16'hFFFF) qc_r <= qc_r + 16'h0001;
    end
  end

  // Frequency switching sequencer.
  assign last = idx_r + (LW+1)'(1) >= an_r;
  assign auto_op = st_r != AF_IDLE || scan_active;
  assign image_irq = image_det && tune_done && !auto_op;
  assign audio_mute = st_r != AF_IDLE && st_r != AF_WAIT;
  assign tune_req = st_r == AF_TUNE || st_r == AF_RET;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= AF_IDLE;
      idx_r <= '0;
      swt_r <= '0;
      pit_r <= '0;
      home_r <= 8'h00;
      tune_freq <= 8'h00;
      on_ta_r <= 1'b0;
    end else begin
      if (st_r != AF_IDLE && st_r != AF_WAIT && st_r != AF_PICHK)
        swt_r <= swt_r + 1'b1;
      case (st_r)
        AF_IDLE: begin
          swt_r <= '0;
          idx_r <= '0;
          if (take && wb_we_i && wb_adr_i == `FRDS_REG_FREQ && wb_sel_i[0])
            home_r <= wb_dat_i[7:0];
          else if (ctrl_r[`FRDS_CTRL_TA_EN] && tp_r &&
                   eon_ta_r != on_ta_r && taf_r != 8'h00) begin
            on_ta_r <= eon_ta_r;
            tune_freq <= eon_ta_r ? taf_r : home_r;
            st_r <= AF_RET;
          end else if (ctrl_r[`FRDS_CTRL_AF_EN] && !on_ta_r && pi_ok_r &&
                       an_r != '0 && rssi < afth_r[7:0]) begin
            st_r <= ctrl_r[`FRDS_CTRL_PAUSE_EN] ? AF_WAIT : AF_TUNE;
            tune_freq <= afl[0];
          end
        end
        AF_WAIT: begin
          if (!ctrl_r[`FRDS_CTRL_AF_EN]) st_r <= AF_IDLE;
          else if (pause) st_r <= AF_TUNE;
        end
        AF_TUNE: st_r <= AF_MEAS;
        AF_MEAS: begin
          if (swt_r >= SWW'(SW_CYC)) begin
            tune_freq <= home_r;
            st_r <= AF_RET;
          end else if (tune_done) begin
            if (cand_rssi >= afth_r[15:8] && !image_det) begin
              pit_r <= '0;
              st_r <= AF_PICHK;
            end else if (last) begin
              tune_freq <= home_r;
              st_r <= AF_RET;
            end else begin
              idx_r <= idx_r + 1'b1;
              tune_freq <= afl[LW'(idx_r + 1'b1)];
              st_r <= AF_TUNE;
            end
          end
        end
        AF_PICHK: begin
          pit_r <= pit_r + 1'b1;
          if (pi_seen && bd == pi_r) begin
            home_r <= tune_freq;
            st_r <= AF_IDLE;
          end else if (pi_seen || pit_r >= PIW'(PI_CYC)) begin
            if (last) begin
              tune_freq <= home_r;
              st_r <= AF_RET;
            end else begin
              idx_r <= idx_r + 1'b1;
              tune_freq <= afl[LW'(idx_r + 1'b1)];
              st_r <= AF_TUNE;
            end
          end
        end
        AF_RET: st_r <= AF_RWAIT;
        AF_RWAIT: if (tune_done) st_r <= AF_IDLE;
        default: st_r <= AF_IDLE;
      endcase
    end
  end
endmodule // frds_top

// ### dv/frds_top_props.sv
// Concurrent checks on the block store's bus, tuner and image interrupt ports.
`timescale 1ns/1ps
module frds_top_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tune_req,
  input wire logic [7:0] tune_freq,
  input wire logic tune_done,
  input wire logic image_det,
  input wire logic image_irq,
  input wire logic audio_mute,
  input wire logic scan_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_ack_latency: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  chk_ack_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus acknowledge without request");
  chk_req_pulse: assert property (tune_req |=> !tune_req)
    else $error("retune request longer than one cycle");
  chk_mute_retune: assert property (
    tune_req |-> audio_mute ##1 audio_mute)
    else $error("audio not muted during retune");
  chk_freq_hold: assert property (
    tune_req |=> $stable(tune_freq) [*3])
    else $error("retune frequency moved after request");
  chk_image_cause: assert property (
    image_irq |-> image_det && tune_done)
    else $error("image interrupt without image result");
  chk_image_auto: assert property (
    (scan_active || audio_mute) |-> !image_irq)
    else $error("image interrupt during autonomous retune");

  cover property (tune_req);
  cover property (tune_done && audio_mute && image_det);
  cover property (wb_ack_o && !tune_req);
endmodule // frds_top_props

bind frds_top frds_top_props i_props (.clk, .reset_n, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .tune_req, .tune_freq, .tune_done, .image_det,
  .image_irq, .audio_mute, .scan_active);

// ### dv/frds_radio_model.sv
// Front end model: radio data bit source and a tuner that answers retunes.
`timescale 1ns/1ps
module frds_radio_model #(
  parameter int DLY = 20,
  parameter logic [63:0] GRP = 64'h0,
  parameter logic [9:0] OFS_A = 10'h0FC,
  parameter logic [9:0] OFS_B = 10'h198,
  parameter logic [9:0] OFS_C = 10'h168,
  parameter logic [9:0] OFS_D = 10'h1B4
) (
  input wire logic clk,
  input wire logic tune_req,
  input wire logic [7:0] cand_lvl,
  input wire logic image_on,
  output logic rds_bit,
  output logic rds_bit_valid,
  output logic tune_done,
  output logic [7:0] cand_rssi,
  output logic image_det
);
  logic in_frame = 1'b0;
  int cnt = 0;
  initial begin
    rds_bit = 1'b0;
    rds_bit_valid = 1'b0;
    tune_done = 1'b0;
    cand_rssi = 8'h00;
    image_det = 1'b0;
  end
  // Measurement results are only meaningful with the done pulse.
  always @(posedge clk) begin
    tune_done <= (cnt == 1);
    cand_rssi <= (cnt == 1) ? cand_lvl : ~cand_rssi;
    image_det <= (cnt == 1) ? image_on : ~image_det;
    if (tune_req === 1'b1)
      cnt <= DLY;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // The data line keeps moving between blocks so nothing stale is seen.
  always @(posedge clk)
    if (!in_frame)
      rds_bit <= ~rds_bit;
  function automatic logic [9:0] crc(input logic [15:0] d);
    logic [9:0] r;
    logic fb;
    r = 10'h000;
    for (int i = 15; i >= 0; i--) begin
      fb = d[i] ^ r[9];
      r = {r[8:0], 1'b0} ^ (fb ? 10'h1B9 : 10'h000);
    end
    return r;
  endfunction
  task automatic send_block(input logic [15:0] d, input logic [9:0] ofs,
                            input int flip);
    logic [25:0] w;
    w = {d, crc(d) ^ ofs};
    if (flip >= 0)
      w[flip] = ~w[flip];
    in_frame = 1'b1;
    for (int i = 25; i >= 0; i--) begin
      @(posedge clk);
      rds_bit <= w[i];
      rds_bit_valid <= 1'b1;
    end
    @(posedge clk);
    rds_bit_valid <= 1'b0;
    in_frame = 1'b0;
  endtask
  task automatic send_group(input int flip);
    send_block(GRP[63:48], OFS_A, -1);
    send_block(GRP[47:32], OFS_B, -1);
    send_block(GRP[31:16], OFS_C, -1);
    send_block(GRP[15:0], OFS_D, flip);
  endtask
endmodule // frds_radio_model

// ### dv/test_frds_top.sv
// Self-checking bench for the block store, switching and pause detection.
`timescale 1ns/1ps
module test_frds_top;
  localparam logic [63:0] GRP = 64'h5A5A_0000_E110_4142;
  localparam logic [7:0] RA [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  localparam logic [31:0] RV [5] = '{32'h13, 32'h43, 32'h40, 32'h3020,
                                     32'h0100_0200};
  logic clk = 1'b0, reset_n = 1'b0, scan_active = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, rssi = 8'hF0, cand_lvl = 8'h28;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic rds_bit, rds_bit_valid, tune_done, image_det, tune_req, audio_mute;
  logic image_irq, fill_irq, scan_accept, image_on = 1'b0;
  logic audio_valid = 1'b0;
  logic signed [15:0] audio_left = 16'sh0400, audio_right = 16'sh0400;
  logic [7:0] cand_rssi, tune_freq;
  int bad_count = 0, checks_done = 0, cyc_n = 0, n;

  frds_top #(.SW_CYC(200), .PI_CYC(2000)) i_dut (.clk, .reset_n,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .rds_bit, .rds_bit_valid, .rssi, .audio_valid,
    .audio_left, .audio_right, .scan_active, .tune_done, .cand_rssi,
    .image_det, .tune_req, .tune_freq, .audio_mute, .image_irq, .fill_irq,
    .scan_accept);
  frds_radio_model #(.GRP(GRP)) i_radio (.clk, .tune_req, .cand_lvl,
    .image_on, .rds_bit, .rds_bit_valid, .tune_done, .cand_rssi,
    .image_det);

  always #4 clk = ~clk;
  always @(posedge clk) audio_valid <= ~audio_valid;
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wait_req(input int lim);
    @(posedge clk);
    n = 0;
    while (tune_req !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  function automatic logic [31:0] ent(input int k, input logic [2:0] e,
                                      input logic b);
    logic [2:0] t;
    t = (k == 3) ? 3'h4 : 3'(k);
    return {8'h00, t, e, b, 1'b0, GRP[63 - 16 * k -: 16]};
  endfunction

  initial begin
    int k;
    logic [2:0] typ;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, RA[i], 32'h0);
      check("reset value", RV[i], q);
    end
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0);
    check("unmapped", 32'h0, q);
    wb(1'b0, 8'h18, 32'h0);
    check("empty pop", 32'h0, q);
    wb(1'b1, 8'h04, 32'h42);
    wb(1'b0, 8'h04, 32'h0);
    check("sync setup", 32'h42, q);
    repeat (25) i_radio.send_group(-1);
    repeat (4) @(posedge clk);
    wb(1'b0, 8'h14, 32'h0);
    check("synced", 32'h1, q[0]);
    check("stored count", 32'd85, q[14:8]);
    check("fill flag", 32'h1, fill_irq);
    wb(1'b0, 8'h1C, 32'h0);
    check("identity", 32'h0300_5A5A, q);
    typ = 3'h7;
    // Entries must come out in stream order and release one by one.
    for (int i = 84; i >= 0; i--) begin
      wb(1'b0, 8'h18, 32'h0);
      if (typ != 3'h7)
        check("type order", (typ == 3'h4) ? 3'h0 : (typ == 3'h2) ?
              3'h4 : typ + 3'h1, q[23:21]);
      typ = q[23:21];
      k = (typ == 3'h4) ? 3 : int'(typ);
      check("entry", ent(k, 3'h0, 1'b0), q);
      check("fill level", i >= 64, fill_irq);
    end
    wb(1'b0, 8'h18, 32'h0);
    check("drained", 32'h0, q);
    i_radio.send_group(20);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'h18, 32'h0);
      check("after overflow", ent(i, (i == 3) ? 3'h1 : 3'h0, i == 0),
            q);
    end
    wb(1'b1, 8'h20, 32'h40);
    wb(1'b1, 8'h00, 32'h19);
    check("scan gate", 32'h0, scan_accept);
    rssi <= 8'h10;
    wait_req(300);
    check("af tune", 32'h110, {n < 300, tune_freq});
    check("mute", 32'h1, audio_mute);
    // Every group repeats one code, so all eight list slots get tried.
    repeat (8) wait_req(300);
    check("weak return", 32'h140, {n < 300, tune_freq});
    rssi <= 8'hF0;
    image_on <= 1'b1;
    cand_lvl <= 8'h38;
    repeat (40) @(posedge clk);
    rssi <= 8'h10;
    repeat (9) wait_req(300);
    check("image return", 32'h140, {n < 300, tune_freq});
    rssi <= 8'hF0;
    image_on <= 1'b0;
    wb(1'b1, 8'h00, 32'h10);
    repeat (40) @(posedge clk);
    rssi <= 8'h10;
    wait_req(300);
    check("af off", 32'h0, n < 300);
    wb(1'b1, 8'h10, 32'h0004_0100);
    wb(1'b1, 8'h00, 32'h13);
    wait_req(300);
    check("loud audio", 32'h0, n < 300);
    audio_right <= -16'sh0400;
    wait_req(300);
    check("pause jump", 32'h1, n >= 6 && n < 300);
    rssi <= 8'hF0;
    repeat (3) i_radio.send_group(-1);
    wb(1'b0, 8'h20, 32'h0);
    check("new home", 32'h10, q[7:0]);
    wb(1'b1, 8'h20, 32'h5510);
    wb(1'b1, 8'h00, 32'h04);
    i_radio.send_block(16'h5A5A, 10'h0FC, -1);
    i_radio.send_block(16'hEC10, 10'h198, -1);
    wait_req(300);
    check("traffic switch", 32'h155, {n < 300, tune_freq});
    close_out();
  end
endmodule // test_frds_top
